// ---- core/spi_port_pkg.sv ----
/*
  Shared constants of the sensor serial slave port: register map entries,
  field positions, reset values and command byte layout.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spi_port_pkg;

  // Register map
  localparam int           ADDR_W       = 6;
  localparam int           DATA_W       = 8;
  localparam logic [5:0]   FMT_OFFSET   = 6'h31;
  localparam logic [7:0]   FMT_RESET    = 8'h00;
  localparam int           WIRE3_BIT    = 6;

  // Command byte layout, most significant bit first
  localparam int           CMD_RD_BIT    = 7;
  localparam int           CMD_BURST_BIT = 6;

  // Bit counter of one byte on the link
  localparam logic [2:0]   BIT_FIRST    = 3'h0;
  localparam logic [2:0]   BIT_LAST     = 3'h7;

  // Link timing as printed, for reference by the surroundings
  localparam int           SCLK_MAX_KHZ = 5000;
  localparam int           CS_GAP_NS    = 250;
  localparam int           MCLK_PER_NS  = 5;
  localparam int           CS_GAP_CYC   =
    (CS_GAP_NS + MCLK_PER_NS - 1) / MCLK_PER_NS;

  // Synchroniser depth for pin inputs
  localparam int           SYNC_STAGES  = 2;

endpackage

// ---- core/reg_bank.sv ----
/*
  Byte-wide register storage of the sensor, one write port and one
  registered read port, all on mclk.
  Assumes address and write data are stable while write enable is high.
*/
`timescale 1ns/10ps
module reg_bank
  import spi_port_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock and control
  input  wire logic          mclk,
  input  wire logic          ce,
  // Access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [(1<<AW)];

  // Storage has no reset; contents are set by software writes
  always_ff @(posedge mclk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  // Read data always from a register
  always_ff @(posedge mclk) begin
    if (ce) begin
      rdata <= mem[addr];
    end
  end

endmodule

// ---- core/sensor_spi_slave_port.sv ----
/*
  Serial slave port of the acceleration sensor: mode 3 SPI in 4-wire or
  3-wire form with burst auto-increment, plus two-wire mode detection.
  Assumes sclk comes from the master and only runs while csN is low, and
  that half an sclk period spans at least 8 mclk cycles so read data
  crossing from the mclk side is settled at the next falling edge.
  Limitation: ce freezes the mclk side only; the link logic runs on
  sclk, so a request toggled twice while ce is low is lost.
  Memory cells have no reset; reading an unwritten cell gives unknowns.
*/
`timescale 1ns/10ps
module sensor_spi_slave_port
  import spi_port_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // System clock, reset and enable
  input  wire logic          mclk,
  input  wire logic          resetn,
  input  wire logic          ce,
  // Serial link pins
  input  wire logic          sclk,
  input  wire logic          csN,
  input  wire logic          sdiIn,
  output logic               sdiOut,
  output logic               sdiOe,
  output logic               sdoOut,
  output logic               sdoOe,
  // Mode and configuration status
  output logic               twoWireSel,
  output logic               threeWire,
  output logic      [DW-1:0] formatCtrl
);

  // Format register address test, used on write and on read
  function automatic logic isFmt(input logic [AW-1:0] a);
    isFmt = (a == FMT_OFFSET);
  endfunction

  // Only the request toggle, its payload, the held read word and the
  // wire bit cross between the sclk and mclk sides
  // Link side, rising edge state (cleared by select high)
  logic          linkClr;
  logic [2:0]    bitCnt_ff;
  logic          cmdDone_ff;
  logic          firstDone_ff;
  logic          rdMode_ff;
  logic          burst_ff;
  logic [AW-1:0] ptr_ff;
  logic [DW-2:0] shIn_ff;
  // Link side, falling edge state
  logic [DW-1:0] shOut_ff;
  logic          outBit_ff;
  logic          drive_ff;
  // Link side request toggle and its payload, then the wire bit synchroniser
  logic          reqTgl_ff;
  logic          reqWr_ff;
  logic [AW-1:0] reqAddr_ff;
  logic [DW-1:0] reqData_ff;
  logic          w3Sync1_ff;
  logic          w3Sync2_ff;
  // Decoded actions at the end of a byte
  logic [DW-1:0] byteIn;
  logic          byteEnd;
  logic          issueRd;
  logic          issueWr;
  logic [AW-1:0] issueAddr;
  // System side
  logic          csSync1_ff;
  logic          csSync2_ff;
  logic          twoWire_ff;
  logic          reqSync1_ff;
  logic          reqSync2_ff;
  logic          reqSync3_ff;
  logic          reqSeen;
  logic          rdPend_ff;
  logic [DW-1:0] rdHold_ff;
  logic [DW-1:0] fmt_ff;
  logic [DW-1:0] memRdata;
  logic          memWe;

  // Select high ends every transaction at once; asynchronous, since
  // sclk stops with the frame and a partial byte must be dropped
  assign linkClr = csN | ~resetn;

  assign byteIn  = {shIn_ff, sdiIn};
  assign byteEnd = (bitCnt_ff == BIT_LAST);

  // What the byte just completed asks for. Reads are fetched a byte
  // ahead: the mclk side needs a few cycles and the word must stand
  // before the falling edge that sends its first bit
  always_comb begin
    issueRd   = 1'b0;
    issueWr   = 1'b0;
    issueAddr = ptr_ff;
    if (byteEnd) begin
      if (!cmdDone_ff) begin
        // Command byte: read bit, burst flag, start address
        issueRd   = byteIn[CMD_RD_BIT];
        issueAddr = byteIn[AW-1:0];
      end else if (!firstDone_ff || burst_ff) begin
        issueWr   = ~rdMode_ff;
        // Next read is prefetched from the advanced pointer
        issueRd   = rdMode_ff & burst_ff;
        issueAddr = (rdMode_ff && burst_ff) ? ptr_ff + 1'b1 : ptr_ff;
      end
    end
  end

  // Input shift and bit count, sampled on the rising edge; sclk idles
  // high, so the first edge of a frame is a falling one and shifts nothing
  always_ff @(posedge sclk or posedge linkClr) begin
    if (linkClr) begin
      bitCnt_ff <= BIT_FIRST;
      shIn_ff   <= '0;
    end else begin
      bitCnt_ff <= bitCnt_ff + 1'b1;
      shIn_ff   <= byteIn[DW-2:0];
    end
  end

  // Transaction state: command decode and pointer. Without the burst
  // flag later bytes leave the pointer alone: reads repeat the byte and
  // writes are dropped
  always_ff @(posedge sclk or posedge linkClr) begin
    if (linkClr) begin
      cmdDone_ff   <= 1'b0;
      firstDone_ff <= 1'b0;
      rdMode_ff    <= 1'b0;
      burst_ff     <= 1'b0;
      ptr_ff       <= '0;
    end else if (byteEnd) begin
      if (!cmdDone_ff) begin
        cmdDone_ff <= 1'b1;
        rdMode_ff  <= byteIn[CMD_RD_BIT];
        burst_ff   <= byteIn[CMD_BURST_BIT];
        ptr_ff     <= byteIn[AW-1:0];
      end else begin
        firstDone_ff <= 1'b1;
        // Pointer wraps within the six bit space
        if (burst_ff) begin
          ptr_ff <= ptr_ff + 1'b1;
        end
      end
    end
  end

  // Request toggle survives select high so no edge is lost. A level
  // change, not a pulse: sclk may stop right after the last rising edge,
  // and a toggle is the one thing the mclk side is sure to see
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      reqTgl_ff  <= 1'b0;
      reqWr_ff   <= 1'b0;
      reqAddr_ff <= '0;
      reqData_ff <= '0;
    end else if (issueRd || issueWr) begin
      reqTgl_ff  <= ~reqTgl_ff;
      reqWr_ff   <= issueWr;
      reqAddr_ff <= issueAddr;
      reqData_ff <= byteIn;
    end
  end

  // Wire mode bit brought onto the link clock. It changes only between
  // frames; the first two rises of a command byte carry it across before
  // the first driven bit
  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      w3Sync1_ff <= 1'b0;
      w3Sync2_ff <= 1'b0;
    end else begin
      w3Sync1_ff <= fmt_ff[WIRE3_BIT];
      w3Sync2_ff <= w3Sync1_ff;
    end
  end

  // Output shift on the falling edge, loaded at each read byte start;
  // the bit then stands across the rise at which the master samples
  always_ff @(negedge sclk or posedge linkClr) begin
    if (linkClr) begin
      shOut_ff  <= '0;
      outBit_ff <= 1'b0;
      drive_ff  <= 1'b0;
    end else if (cmdDone_ff && rdMode_ff && bitCnt_ff == BIT_FIRST) begin
      // Held word is settled: it was requested half a period earlier
      outBit_ff <= rdHold_ff[DW-1];
      shOut_ff  <= {rdHold_ff[DW-2:0], 1'b0};
      drive_ff  <= 1'b1;
    end else begin
      outBit_ff <= shOut_ff[DW-1];
      shOut_ff  <= {shOut_ff[DW-2:0], 1'b0};
      drive_ff  <= cmdDone_ff & rdMode_ff;
    end
  end

  // Pin drivers: only data lines, never clock or select. Both outputs
  // carry the same bit; the enables alone pick the line, never both
  assign sdoOut = outBit_ff;
  assign sdiOut = outBit_ff;
  assign sdoOe  = drive_ff & ~w3Sync2_ff;
  assign sdiOe  = drive_ff & w3Sync2_ff;
  assign threeWire = w3Sync2_ff;

  // Select pin synchroniser on the system clock; csN bears no relation
  // to mclk, hence two stages before the mode flag reads it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      csSync1_ff <= 1'b1;
      csSync2_ff <= 1'b1;
    end else if (ce) begin
      csSync1_ff <= csN;
      csSync2_ff <= csSync1_ff;
    end
  end

  // Two-wire mode stands until select is ever seen low. Only the flag
  // is kept here; no two-wire protocol sits behind it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      twoWire_ff <= 1'b1;
    end else if (ce && !csSync2_ff) begin
      twoWire_ff <= 1'b0;
    end
  end
  assign twoWireSel = twoWire_ff;

  // Request toggle crossing; payload is stable once the edge shows.
  // The third stage only serves edge detection; the payload changes no
  // sooner than a byte later, long after it has been used
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reqSync1_ff <= 1'b0;
      reqSync2_ff <= 1'b0;
      reqSync3_ff <= 1'b0;
    end else if (ce) begin
      reqSync1_ff <= reqTgl_ff;
      reqSync2_ff <= reqSync1_ff;
      reqSync3_ff <= reqSync2_ff;
    end
  end
  assign reqSeen = reqSync2_ff ^ reqSync3_ff;
  assign memWe   = reqSeen & reqWr_ff;

  // Format register copy steers the wire count; a plain register, so
  // the link side can synchronise the wire bit without touching memory
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fmt_ff <= FMT_RESET;
    end else if (ce && memWe && isFmt(reqAddr_ff)) begin
      fmt_ff <= reqData_ff;
    end
  end
  assign formatCtrl = fmt_ff;

  // Read word held for the link; memory answers one cycle later. The
  // link reads it with no synchroniser, which is safe only because it
  // settles long before the falling edge that takes it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdPend_ff <= 1'b0;
      rdHold_ff <= '0;
    end else if (ce) begin
      rdPend_ff <= reqSeen & ~reqWr_ff;
      if (rdPend_ff) begin
        rdHold_ff <= isFmt(reqAddr_ff) ? fmt_ff : memRdata;
      end
    end
  end

  // Register storage; its registered read is why a pending stage
  // stands between the request and the held word
  reg_bank #(
    .AW (AW),
    .DW (DW)
  ) u_bank (
    .mclk  (mclk),
    .ce    (ce),
    .we    (memWe),
    .addr  (reqAddr_ff),
    .wdata (reqData_ff),
    .rdata (memRdata)
  );

endmodule

// ---- dv/spi_port_checker_assertions.sv ----
/*
  Checker of the serial port pins and mode outputs on mclk.
  Assumes resetn is the asynchronous reset of the mclk domain.
*/
`timescale 1ns/10ps
module spi_port_checker
  import spi_port_pkg::*;
#(
  parameter int DW = DATA_W
) (
  // Clock, reset and link inputs
  input wire logic          mclk,
  input wire logic          resetn,
  input wire logic          sclk,
  input wire logic          csN,
  // Device outputs
  input wire logic          sdoOut,
  input wire logic          sdoOe,
  input wire logic          sdiOe,
  input wire logic          twoWireSel,
  input wire logic          threeWire,
  input wire logic [DW-1:0] formatCtrl
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Select held low long enough to pass the synchroniser
  sequence csHeld;
    !csN [*6];
  endsequence
  a_oe_one_line: assert property (!(sdoOe && sdiOe))
    else $error("both data lines driven");
  a_oe_needs_cs: assert property (csN |-> !sdoOe && !sdiOe)
    else $error("line driven while deselected");
  a_sdo_four_wire: assert property
    (sdoOe |-> !formatCtrl[WIRE3_BIT])
    else $error("sdo driven in 3-wire mode");
  a_sdi_three_wire: assert property
    (sdiOe |-> formatCtrl[WIRE3_BIT])
    else $error("sdi driven in 4-wire mode");
  a_sdo_on_fall: assert property
    ($changed(sdoOut) && sdoOe && $past(sdoOe) |-> !sclk)
    else $error("sdo changed outside clock low");
  a_two_wire_hold: assert property (!twoWireSel |=> !twoWireSel)
    else $error("two-wire mode came back");
  a_two_wire_exit: assert property (csHeld |-> !twoWireSel)
    else $error("two-wire mode kept with select low");
  a_wire_follows: assert property
    ($rose(threeWire) |-> formatCtrl[WIRE3_BIT])
    else $error("3-wire without format bit");
  a_reset_values: assert property
    ($rose(resetn) |-> twoWireSel && !threeWire && formatCtrl == FMT_RESET)
    else $error("bad values after reset");
endmodule

bind sensor_spi_slave_port spi_port_checker #(.DW(DW)) u_chk (
  .mclk(mclk), .resetn(resetn), .sclk(sclk), .csN(csN), .sdoOut(sdoOut),
  .sdoOe(sdoOe), .sdiOe(sdiOe), .twoWireSel(twoWireSel),
  .threeWire(threeWire), .formatCtrl(formatCtrl));

// ---- dv/spi_master_model.sv ----
/*
  Behavioural mode 3 SPI master: frames, clocks, shifts and samples.
  Assumes the bench fills txBuf before calling frame.
*/
`timescale 1ns/10ps
module spi_master_model #(
  parameter int HALF = 100
) (
  // Pins driven by the master
  output logic      sclk,
  output logic      csN,
  output logic      sdiIn,
  // Device outputs
  input  wire logic sdiOut,
  input  wire logic sdiOe,
  input  wire logic sdoOut,
  input  wire logic sdoOe
);
  logic [7:0] txBuf [8];
  logic [7:0] rxBuf [8];
  logic       mosi;
  logic       rel;
  logic       sdoLine;
  // Released sdo shows the inverse, so a missing enable is caught
  assign sdoLine = sdoOe ? sdoOut : ~sdoOut;
  // Shared line; a released master lets it wander, no pull exists
  assign sdiIn = sdiOe ? sdiOut : mosi;
  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    mosi = 1'b1;
    rel  = 1'b0;
  end
  // One byte, MSB first: drive on fall, sample on rise
  task automatic xbyte(input logic [7:0] tx, input logic w3,
                       output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = rel ? ~mosi : tx[i];
      #HALF;
      sclk = 1'b1;
      rx[i] = w3 ? sdiIn : sdoLine;
      #HALF;
    end
  endtask
  // Whole transaction; returned data of writes is never used
  task automatic frame(input logic [7:0] cmd, input int n, input logic w3);
    logic [7:0] junk;
    csN = 1'b0;
    #50;
    xbyte(cmd, w3, junk);
    rel = w3 & cmd[7];
    for (int k = 0; k < n; k++) xbyte(txBuf[k], w3, rxBuf[k]);
    #50;
    csN  = 1'b1;
    rel  = 1'b0;
    mosi = 1'b1;
    #300;
  endtask
endmodule

// ---- dv/testbench.sv ----
/*
  Self-checking bench of the sensor serial port with a master model.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import spi_port_pkg::*;
  logic              mclk;
  logic              resetn;
  logic              ce;
  logic              sclk, csN, sdiIn, sdiOut, sdiOe, sdoOut, sdoOe;
  logic              twoWireSel, threeWire;
  logic [DATA_W-1:0] formatCtrl;
  int                mismatches;
  int                check_count;

  // 200 MHz system clock
  always #2.5 mclk = ~mclk;

  sensor_spi_slave_port u_dut (.mclk(mclk), .resetn(resetn), .ce(ce),
    .sclk(sclk), .csN(csN), .sdiIn(sdiIn), .sdiOut(sdiOut), .sdiOe(sdiOe),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .twoWireSel(twoWireSel),
    .threeWire(threeWire), .formatCtrl(formatCtrl));
  spi_master_model #(.HALF(100)) u_m (.sclk(sclk), .csN(csN),
    .sdiIn(sdiIn), .sdiOut(sdiOut), .sdiOe(sdiOe), .sdoOut(sdoOut),
    .sdoOe(sdoOe));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Frames start on a falling mclk edge
  task automatic go(input logic [7:0] cmd, input int n, input logic w3);
    @(negedge mclk);
    u_m.frame(cmd, n, w3);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    u_m.txBuf[0] = a;
    u_m.txBuf[1] = b;
    u_m.txBuf[2] = 8'hc3;
  endtask

  task automatic t_reset;
    chk("twoWireSel", 8'h01, {7'h0, twoWireSel});
    chk("formatCtrl", FMT_RESET, formatCtrl);
    chk("threeWire", 8'h00, {7'h0, threeWire});
    $display("reset test done");
  endtask
  // Burst write and read back at 0x10, then wrap past 0x3f
  task automatic t_burst;
    put(8'haa, 8'h55);
    go(8'h50, 3, 1'b0);
    go(8'hd0, 3, 1'b0);
    chk("twoWireSel", 8'h00, {7'h0, twoWireSel});
    for (int k = 0; k < 3; k++) begin
      chk("burst", u_m.txBuf[k], u_m.rxBuf[k]);
    end
    put(8'h5a, 8'ha5);
    go(8'h7f, 2, 1'b0);
    go(8'h80, 1, 1'b0);
    chk("wrap", 8'ha5, u_m.rxBuf[0]);
    $display("burst test done");
  endtask
  // Without burst flag the second byte must not advance
  task automatic t_single;
    put(8'h11, 8'h00);
    go(8'h21, 1, 1'b0);
    put(8'h22, 8'h33);
    go(8'h20, 2, 1'b0);
    go(8'he0, 2, 1'b0);
    chk("single0", 8'h22, u_m.rxBuf[0]);
    chk("single1", 8'h11, u_m.rxBuf[1]);
    $display("single test done");
  endtask
  // Switch to 3-wire, read on the shared line, switch back
  task automatic t_wire3;
    put(8'h40, 8'h00);
    go({2'b00, FMT_OFFSET}, 1, 1'b0);
    chk("formatCtrl", 8'h40, formatCtrl);
    go(8'h90, 1, 1'b1);
    chk("rd3", 8'haa, u_m.rxBuf[0]);
    chk("threeWire", 8'h01, {7'h0, threeWire});
    go({2'b10, FMT_OFFSET}, 1, 1'b1);
    chk("fmt rd", 8'h40, u_m.rxBuf[0]);
    put(8'h00, 8'h00);
    go({2'b00, FMT_OFFSET}, 1, 1'b1);
    go(8'h90, 1, 1'b0);
    chk("rd4", 8'haa, u_m.rxBuf[0]);
    chk("threeWire", 8'h00, {7'h0, threeWire});
    $display("wire test done");
  endtask
  // Enable low holds the mclk side; the write lands once it rises
  task automatic t_ce;
    put(8'h40, 8'h00);
    @(negedge mclk);
    ce = 1'b0;
    go({2'b00, FMT_OFFSET}, 1, 1'b0);
    chk("formatCtrl", 8'h00, formatCtrl);
    ce = 1'b1;
    repeat (6) @(negedge mclk);
    chk("formatCtrl", 8'h40, formatCtrl);
    $display("enable test done");
  endtask

  initial begin
    mclk   = 1'b0;
    resetn = 1'b0;
    ce     = 1'b1;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset();
    t_burst();
    t_single();
    t_wire3();
    t_ce();
    end_sim();
  end
  // Watchdog well beyond the roughly 60 us of traffic
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
endmodule
